//--- logic/sqs_scheduler.sv
// Functional notes
// [R1] Multicast rate limit acts where replications leave receive queues into expansion queues.
// [R2] One limiter serves first-level and second-level expansion alike.
// [R3] Each class has its own frame-rate limit plus a total multicast cap.
// [R4] Limits count frames per second, never bytes.
// [R5] One global limiter configuration, not one per port.
// [R6] Strict service drains the highest non-empty strict class before lower ones.
// [R7] Among strict classes the higher number wins.
// [R8] Weighted service visits classes in fixed order, wrapping from lowest to highest.
// [R9] Excess sent is kept as negative deficit, reducing following allocations.
// [R10] Eight traffic classes 0 to 7; higher number is higher priority.
// [R11] Configured count makes that many top classes strict, rest weighted.
// [R12] With N strict, class 7 is level N downward; weighted slot is class+1.
// [R13] All strict classes go before any weighted class.
// [R14] Queues sharing one class are equal peers, alternated within that class.
// [R15] Multicast class c inherits the service of unicast class c.
// [R16] Multicast expansion queues join their class exactly like unicast queues.
// [R17] An empty weighted class loses its deficit credit.
// [R18] Rate counters refill once per second; exhausted class or total holds replication.
`timescale 1ns/1ns
`default_nettype none
`include "sqs_consts.svh"

module sqs_fifo #(
    parameter int WIDTH = `SQS_DESC_W,
    parameter int DEPTH = `SQS_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic full_reg, full_next, valid_reg, valid_next;
    logic [WIDTH-1:0] head_reg, head_next;
    logic push, pop;

    assign in_ready = !full_reg;
    // Head word and valid sit in their own flops so the read side is registered.
    assign out_valid = valid_reg;
    assign out_data = head_reg;

    always_comb begin
        push = in_valid && !full_reg;
        pop = out_ready && valid_reg;
        mem_next = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
        full_next = (count_next == (AW + 1)'(DEPTH));
        valid_next = (count_next != '0);
        head_next = mem_next[rd_ptr_next];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            full_reg <= 1'b0;
            valid_reg <= 1'b0;
            head_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            full_reg <= full_next;
            valid_reg <= valid_next;
            head_reg <= head_next;
        end
    end
endmodule : sqs_fifo

module sqs_scheduler #(
    parameter int unsigned SEC_CYCLES = `SQS_SEC_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] cfg_sp_count,
    input wire logic [`SQS_NUM_TC*`SQS_WEIGHT_W-1:0] cfg_wrr_weight,
    input wire logic [`SQS_NUM_TC*`SQS_RATE_W-1:0] cfg_mc_class_rate,
    input wire logic [`SQS_RATE_W-1:0] cfg_mc_total_rate,
    input wire logic [`SQS_NUM_TC-1:0] uc_nonempty,
    input wire logic [`SQS_NUM_TC-1:0] mc_nonempty,
    input wire logic [`SQS_NUM_TC*`SQS_LEN_W-1:0] uc_head_len,
    input wire logic [`SQS_NUM_TC*`SQS_LEN_W-1:0] mc_head_len,
    output logic [`SQS_NUM_TC-1:0] uc_deq,
    output logic [`SQS_NUM_TC-1:0] mc_deq,
    input wire logic [`SQS_NUM_TC-1:0] mc_repl_req,
    output logic [`SQS_NUM_TC-1:0] mc_repl_grant,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic tx_mcast,
    output logic [2:0] tx_class,
    output logic [`SQS_LEN_W-1:0] tx_len
);
    // Returns {found, index} of the highest set bit.
    function automatic logic [3:0] sqs_top_bit(input logic [`SQS_NUM_TC-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < `SQS_NUM_TC; i++) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction : sqs_top_bit

    function automatic logic [`SQS_LEN_W-1:0] sqs_len_of(
        input logic [`SQS_NUM_TC*`SQS_LEN_W-1:0] v,
        input sqs_pkg::sqs_tc_t c
    );
        return v[c*`SQS_LEN_W +: `SQS_LEN_W];
    endfunction : sqs_len_of

    sqs_pkg::sqs_state_t state_reg, state_next;
    sqs_pkg::sqs_tc_t ptr_reg, ptr_next;
    logic [`SQS_NUM_TC-1:0] rr_reg, rr_next;
    logic signed [`SQS_DEFICIT_W-1:0] deficit_reg [`SQS_NUM_TC];
    logic signed [`SQS_DEFICIT_W-1:0] deficit_next [`SQS_NUM_TC];
    logic [`SQS_NUM_TC-1:0] uc_deq_reg, uc_deq_next, mc_deq_reg, mc_deq_next;
    logic [`SQS_NUM_TC-1:0] tc_ne, wrr_mask;
    logic [3:0] sp_pick;
    logic grant, grant_wrr, g_mc;
    sqs_pkg::sqs_tc_t g_cls;
    logic [`SQS_LEN_W-1:0] g_len;
    logic fifo_in_ready;
    logic [`SQS_DESC_W-1:0] fifo_out;

    assign uc_deq = uc_deq_reg;
    assign mc_deq = mc_deq_reg;
    assign tx_mcast = fifo_out[`SQS_DESC_MC_BIT];
    assign tx_class = fifo_out[`SQS_DESC_TC_MSB:`SQS_DESC_TC_LSB];
    assign tx_len = fifo_out[`SQS_LEN_W-1:0];

    always_comb begin
        for (int c = 0; c < `SQS_NUM_TC; c++) begin
            // Multicast class c shares the service of unicast class c.
            tc_ne[c] = uc_nonempty[c] | mc_nonempty[c]; // [R15] [R16]
            wrr_mask[c] = (5'(c) + 5'(cfg_sp_count)) < 5'h08; // [R10] [R11] [R12]
        end
    end

    always_comb begin
        state_next = state_reg;
        ptr_next = ptr_reg;
        rr_next = rr_reg;
        deficit_next = deficit_reg;
        uc_deq_next = '0;
        mc_deq_next = '0;
        grant = 1'b0;
        grant_wrr = 1'b0;
        g_mc = 1'b0;
        g_cls = 3'h0;
        g_len = '0;
        sp_pick = sqs_top_bit(tc_ne & ~wrr_mask); // [R6] [R7]
        unique case (state_reg)
            sqs_pkg::SQS_ST_WAIT: begin
                state_next = sqs_pkg::SQS_ST_PICK;
            end
            sqs_pkg::SQS_ST_PICK: begin
                if (fifo_in_ready) begin
                    if (sp_pick[3]) begin
                        grant = 1'b1; // [R13]
                        g_cls = sp_pick[2:0];
                    end else if (tc_ne[ptr_reg] && wrr_mask[ptr_reg]
                                 && deficit_reg[ptr_reg] > 24'sh000000) begin
                        grant = 1'b1;
                        grant_wrr = 1'b1;
                        g_cls = ptr_reg;
                    end else if (|(tc_ne & wrr_mask)) begin
                        // Step down one class, wrapping from 0 back to 7.
                        ptr_next = ptr_reg - 3'h1; // [R8]
                        if (tc_ne[ptr_next] && wrr_mask[ptr_next]) begin
                            deficit_next[ptr_next] = deficit_reg[ptr_next]
                                + $signed({10'h000,
                                  cfg_wrr_weight[ptr_next*`SQS_WEIGHT_W +: `SQS_WEIGHT_W],
                                  6'h00});
                        end
                    end
                end
            end
        endcase
        if (grant) begin
            // Unicast and multicast queues of one class alternate.
            g_mc = mc_nonempty[g_cls] && (!uc_nonempty[g_cls] || rr_reg[g_cls]); // [R14]
            if (uc_nonempty[g_cls] && mc_nonempty[g_cls]) begin
                rr_next[g_cls] = !rr_reg[g_cls]; // [R14]
            end
            g_len = g_mc ? sqs_len_of(mc_head_len, g_cls) : sqs_len_of(uc_head_len, g_cls);
            uc_deq_next[g_cls] = !g_mc;
            mc_deq_next[g_cls] = g_mc;
            state_next = sqs_pkg::SQS_ST_WAIT;
            if (grant_wrr) begin
                // Overshoot stays as negative credit for later rounds.
                deficit_next[g_cls] = deficit_reg[g_cls]
                    - $signed({8'h00, g_len}); // [R9]
            end
        end
        for (int c = 0; c < `SQS_NUM_TC; c++) begin
            if (!tc_ne[c] || !wrr_mask[c]) begin
                deficit_next[c] = 24'sh000000; // [R17]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= sqs_pkg::SQS_ST_PICK;
            ptr_reg <= 3'h7;
            rr_reg <= '0;
            for (int c = 0; c < `SQS_NUM_TC; c++) begin
                deficit_reg[c] <= 24'sh000000;
            end
            uc_deq_reg <= '0;
            mc_deq_reg <= '0;
        end else begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
            rr_reg <= rr_next;
            deficit_reg <= deficit_next;
            uc_deq_reg <= uc_deq_next;
            mc_deq_reg <= mc_deq_next;
        end
    end

    sqs_fifo #(
        .WIDTH(`SQS_DESC_W),
        .DEPTH(`SQS_FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(grant),
        .in_ready(fifo_in_ready),
        .in_data({g_mc, g_cls, g_len}),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(fifo_out)
    );

    // Multicast replication limiter, shared by both expansion levels.
    logic [`SQS_RATE_W-1:0] tok_reg [`SQS_NUM_TC];
    logic [`SQS_RATE_W-1:0] tok_next [`SQS_NUM_TC];
    logic [`SQS_RATE_W-1:0] tot_reg, tot_next;
    logic [`SQS_SEC_CNT_W-1:0] sec_reg, sec_next;
    logic [`SQS_NUM_TC-1:0] repl_grant_reg, repl_grant_next, tok_avail;
    logic [3:0] repl_pick;

    assign mc_repl_grant = repl_grant_reg;

    always_comb begin
        tok_next = tok_reg;
        tot_next = tot_reg;
        repl_grant_next = '0;
        sec_next = sec_reg + 1'b1;
        for (int c = 0; c < `SQS_NUM_TC; c++) begin
            tok_avail[c] = (tok_reg[c] != '0); // [R3]
        end
        repl_pick = sqs_top_bit(mc_repl_req & tok_avail); // [R1] [R2] [R5]
        if (sec_reg == `SQS_SEC_CNT_W'(SEC_CYCLES - 1)) begin
            sec_next = '0;
            tot_next = cfg_mc_total_rate; // [R18]
            for (int c = 0; c < `SQS_NUM_TC; c++) begin
                tok_next[c] = cfg_mc_class_rate[c*`SQS_RATE_W +: `SQS_RATE_W]; // [R18]
            end
        end else if (repl_pick[3] && tot_reg != '0) begin
            // One token is one frame, whatever its size.
            tok_next[repl_pick[2:0]] = tok_reg[repl_pick[2:0]] - 1'b1; // [R4]
            tot_next = tot_reg - 1'b1; // [R3]
            repl_grant_next[repl_pick[2:0]] = 1'b1; // [R1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int c = 0; c < `SQS_NUM_TC; c++) begin
                tok_reg[c] <= '0;
            end
            tot_reg <= '0;
            sec_reg <= '0;
            repl_grant_reg <= '0;
        end else begin
            tok_reg <= tok_next;
            tot_reg <= tot_next;
            sec_reg <= sec_next;
            repl_grant_reg <= repl_grant_next;
        end
    end
endmodule : sqs_scheduler

`default_nettype wire

//--- logic/sqs_consts.svh
`ifndef SQS_CONSTS_SVH
`define SQS_CONSTS_SVH

`define SQS_NUM_TC 8
`define SQS_LEN_W 16
`define SQS_WEIGHT_W 8
`define SQS_RATE_W 24
`define SQS_DEFICIT_W 24
`define SQS_QUANTUM_SHIFT 6
`define SQS_FIFO_DEPTH 32
`define SQS_DESC_W 20
`define SQS_DESC_MC_BIT 19
`define SQS_DESC_TC_MSB 18
`define SQS_DESC_TC_LSB 16
`define SQS_CLK_PERIOD_NS 8
`define SQS_REFILL_PERIOD_NS 1000000000
`define SQS_SEC_CYCLES (`SQS_REFILL_PERIOD_NS / `SQS_CLK_PERIOD_NS)
`define SQS_SEC_CNT_W 27

`endif

//--- logic/sqs_pkg.sv
`default_nettype none
package sqs_pkg;

    typedef enum logic [0:0] {
        SQS_ST_PICK = 1'b0,
        SQS_ST_WAIT = 1'b1
    } sqs_state_t;

    typedef logic [2:0] sqs_tc_t;

endpackage : sqs_pkg
`default_nettype wire

//--- tb/sqs_queue_model.sv
`timescale 1ns/1ns
`default_nettype none
module sqs_queue_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [31:0] load_uc,
    input wire logic [31:0] load_mc,
    input wire logic [7:0] uc_deq,
    input wire logic [7:0] mc_deq,
    output logic [7:0] uc_nonempty,
    output logic [7:0] mc_nonempty
);
    logic [3:0] uc_cnt [8];
    logic [3:0] mc_cnt [8];
    always_ff @(posedge sys_clk) begin
        for (int c = 0; c < 8; c++) begin
            if (!rst_n) begin
                uc_cnt[c] <= 4'h0;
                mc_cnt[c] <= 4'h0;
            end else if (load) begin
                uc_cnt[c] <= load_uc[4*c+:4];
                mc_cnt[c] <= load_mc[4*c+:4];
            end else begin
                uc_cnt[c] <= uc_cnt[c] - 4'(uc_deq[c]);
                mc_cnt[c] <= mc_cnt[c] - 4'(mc_deq[c]);
            end
        end
    end
    always_comb begin
        for (int c = 0; c < 8; c++) begin
            uc_nonempty[c] = uc_cnt[c] != 4'h0;
            mc_nonempty[c] = mc_cnt[c] != 4'h0;
        end
    end
endmodule : sqs_queue_model
`default_nettype wire

//--- tb/sqs_scheduler_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sqs_scheduler_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] cfg_sp_count,
    input wire logic [7:0] uc_nonempty,
    input wire logic [7:0] mc_nonempty,
    input wire logic [7:0] uc_deq,
    input wire logic [7:0] mc_deq,
    input wire logic [7:0] mc_repl_req,
    input wire logic [7:0] mc_repl_grant,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_mcast,
    input wire logic [2:0] tx_class,
    input wire logic [15:0] tx_len
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] deq_cls;
    logic [7:0] top_strict;
    assign deq_cls = uc_deq | mc_deq;
    // Highest non-empty class that the current count makes strict.
    always_comb begin
        top_strict = 8'h00;
        for (int c = 0; c < 8; c++) begin
            if ((uc_nonempty[c] || mc_nonempty[c]) && c + cfg_sp_count >= 8) begin
                top_strict = 8'h01 << c;
            end
        end
    end
    sequence deq_pulse;
        deq_cls != 8'h00;
    endsequence
    sequence deq_quiet;
        deq_cls == 8'h00;
    endsequence
    chk_deq_onehot: assert property ($onehot0({uc_deq, mc_deq}))
        else $error("two queues popped at once");
    chk_deq_spacing: assert property (deq_pulse |=> deq_quiet)
        else $error("pops closer than two cycles");
    chk_deq_source: assert property (deq_pulse |->
        ((uc_deq & ~$past(uc_nonempty)) | (mc_deq & ~$past(mc_nonempty))) == 8'h00)
        else $error("empty queue popped");
    chk_strict_order: assert property (deq_cls != 8'h00 && $past(top_strict) != 8'h00
        |-> deq_cls == $past(top_strict))
        else $error("strict order broken");
    chk_grant_onehot: assert property ($onehot0(mc_repl_grant))
        else $error("two replication grants at once");
    chk_grant_cause: assert property (mc_repl_grant != 8'h00
        |-> (mc_repl_grant & ~$past(mc_repl_req)) == 8'h00)
        else $error("grant without request");
    chk_tx_stand: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable({tx_mcast, tx_class, tx_len}))
        else $error("head descriptor moved while stalled");
    chk_deq_fills: assert property (deq_pulse |-> tx_valid)
        else $error("popped frame missing from transmit queue");
    chk_head_class: assert property (!$past(tx_valid) && deq_cls != 8'h00
        |-> deq_cls == 8'h01 << tx_class)
        else $error("head class differs from popped class");
endmodule : sqs_scheduler_properties
`default_nettype wire

//--- tb/sqs_scheduler_test.sv
`timescale 1ns/1ns
`default_nettype none
module sqs_scheduler_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] cfg_sp_count = 4'h8;
    logic [63:0] cfg_wrr_weight = 64'h0101010101010101;
    logic [191:0] cfg_mc_class_rate = 192'h0;
    logic [23:0] cfg_mc_total_rate = 24'h000003;
    logic [7:0] uc_nonempty;
    logic [7:0] mc_nonempty;
    logic [7:0] uc_deq;
    logic [7:0] mc_deq;
    logic [7:0] mc_repl_req = 8'hA8;
    logic [7:0] mc_repl_grant;
    logic [127:0] uc_head_len = 128'h0;
    logic [127:0] mc_head_len = 128'h0;
    logic tx_valid;
    logic tx_ready = 1'b0;
    logic tx_mcast;
    logic [2:0] tx_class;
    logic [15:0] tx_len;
    logic load = 1'b0;
    logic [31:0] load_uc = 32'h0;
    logic [31:0] load_mc = 32'h0;
    logic [19:0] seen[$];
    int fails = 0;
    int samples_checked = 0;
    always #4 sys_clk = ~sys_clk;
    sqs_scheduler #(.SEC_CYCLES(50)) u_dut (.sys_clk, .rst_n, .cfg_sp_count, .cfg_wrr_weight,
        .cfg_mc_class_rate, .cfg_mc_total_rate, .uc_nonempty, .mc_nonempty, .uc_head_len,
        .mc_head_len, .uc_deq, .mc_deq, .mc_repl_req, .mc_repl_grant, .tx_valid, .tx_ready,
        .tx_mcast, .tx_class, .tx_len);
    sqs_queue_model u_queues (.sys_clk, .rst_n, .load, .load_uc, .load_mc, .uc_deq, .mc_deq,
        .uc_nonempty, .mc_nonempty);
    always @(posedge sys_clk) begin
        if (rst_n && tx_valid && tx_ready) begin
            seen.push_back({tx_mcast, tx_class, tx_len});
        end
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, want, got);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Class of the n-th departure when classes drain strictly from the top.
    function automatic logic [2:0] nth_class(input logic [31:0] uc, input logic [31:0] mc,
                                             input int n);
        int left = n;
        for (int c = 7; c >= 0; c--) begin
            left -= int'(uc[4*c+:4]) + int'(mc[4*c+:4]);
            if (left < 0) return 3'(c);
        end
        return 3'h0;
    endfunction : nth_class
    task automatic run(input logic [3:0] sp, input logic [31:0] uc, input logic [31:0] mc,
                       input logic [15:0] len, input bit ordered);
        int n = 0;
        int guard = 0;
        logic [15:0] want;
        for (int c = 0; c < 8; c++) begin
            n += int'(uc[4*c+:4]) + int'(mc[4*c+:4]);
        end
        @(negedge sys_clk);
        cfg_sp_count = sp;
        uc_head_len = len != 16'h0 ? {8{len}} : {$urandom, $urandom, $urandom, $urandom};
        mc_head_len = {$urandom, $urandom, $urandom, $urandom};
        load_uc = uc;
        load_mc = mc;
        load = 1'b1;
        seen.delete();
        @(negedge sys_clk);
        load = 1'b0;
        while (seen.size() < n && guard < 4000) begin
            tx_ready = $urandom_range(3) != 0;
            guard++;
            @(negedge sys_clk);
        end
        check("departures", 32'(seen.size()), 32'(n));
        foreach (seen[i]) begin
            want = seen[i][19] ? mc_head_len[16*seen[i][18:16]+:16]
                               : uc_head_len[16*seen[i][18:16]+:16];
            check("tx_len", 32'(seen[i][15:0]), 32'(want));
            if (ordered) check("tx_class", 32'(seen[i][18:16]), 32'(nth_class(uc, mc, i)));
        end
    endtask : run
    initial begin
        int k = 0;
        int n3 = 0;
        int gcnt[8] = '{default: 0};
        void'($urandom(32'h37E3187F));
        cfg_mc_class_rate[72+:24] = 24'h000002;
        cfg_mc_class_rate[120+:24] = 24'h000002;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        while (mc_repl_grant === 8'h00 && k < 200) begin
            k++;
            @(negedge sys_clk);
        end
        for (int i = 0; i < 150; i++) begin
            foreach (gcnt[c]) gcnt[c] += int'(mc_repl_grant[c]);
            @(negedge sys_clk);
        end
        check("class5 grants", 32'(gcnt[5]), 32'h6);
        check("class3 grants", 32'(gcnt[3]), 32'h3);
        check("class7 grants", 32'(gcnt[7]), 32'h0);
        mc_repl_req = 8'h00;
        run(4'h8, 32'h20200200, 32'h0, 16'h0, 1'b1);
        run(4'h8, 32'h02000000, 32'h02000000, 16'h0, 1'b1);
        for (int i = 1; i < 4; i++) check("mc alternate", 32'(seen[i][19] ^ seen[i-1][19]), 32'h1);
        run(4'h4, 32'h00020030, 32'h00100000, 16'h0100, 1'b1);
        repeat (3) run(4'h8, $urandom & 32'h33333333, $urandom & 32'h33333333, 16'h0, 1'b1);
        cfg_wrr_weight[24+:8] = 8'h02;
        run(4'h0, 32'h00008800, 32'h0, 16'h0040, 1'b0);
        for (int i = 0; i < 6; i++) n3 += int'(seen[i][18:16] == 3'h3);
        check("weighted share", 32'(n3), 32'h4);
        tally_and_finish();
    end
    initial begin
        #160000;
        fails++;
        tally_and_finish();
    end
endmodule : sqs_scheduler_test
bind sqs_scheduler sqs_scheduler_properties u_chk (.sys_clk, .rst_n, .cfg_sp_count,
    .uc_nonempty, .mc_nonempty, .uc_deq, .mc_deq, .mc_repl_req, .mc_repl_grant, .tx_valid,
    .tx_ready, .tx_mcast, .tx_class, .tx_len);
`default_nettype wire
